// [core/ais_cfg.svh]
`ifndef AIS_CFG_SVH
`define AIS_CFG_SVH

// Register indices (word offsets on the plain register port)
`define AIS_ADDR_W 3
`define AIS_IDX_MUX_SEL 3'h0
`define AIS_IDX_PIN_LO 3'h1
`define AIS_IDX_PIN_HI 3'h2
`define AIS_IDX_SCAN_MASK 3'h3
`define AIS_IDX_CONTROL 3'h4
`define AIS_IDX_STATUS 3'h5
`define AIS_IDX_SAMPLE 3'h6

// Field positions
`define AIS_NEG_B_BIT 15
`define AIS_POS_B_HI 12
`define AIS_POS_B_LO 8
`define AIS_NEG_A_BIT 7
`define AIS_POS_A_HI 4
`define AIS_POS_A_LO 0
`define AIS_MUX_SEL_MASK 16'h9F9F
`define AIS_PIN_HI_MASK 16'h0003
`define AIS_BG_BIT 1
`define AIS_HBG_BIT 0
`define AIS_CTL_ALT_BIT 0
`define AIS_CTL_SCAN_BIT 10
`define AIS_CTL_DIV_HI 7
`define AIS_CTL_DIV_LO 0
`define AIS_CTL_MASK 16'h04FF

// Positive select codes
`define AIS_CODE_HALF_BG 5'h10
`define AIS_CODE_FULL_BG 5'h11
`define AIS_CODE_LAST_AN 5'h0F
// Scan pointer value meaning no scan sample taken yet
`define AIS_SCAN_NONE 5'h1F

// Reset values
`define AIS_RESET_WORD 16'h0000
`define AIS_RESET_DIV 8'h00

`endif

// [core/ais_pkg.sv]
package ais_pkg;
  typedef enum logic [1:0] {
    AIS_SRC_ANALOG,
    AIS_SRC_HALF_BG,
    AIS_SRC_FULL_BG,
    AIS_SRC_NONE
  } ais_src_t;

  typedef enum logic {
    AIS_NEG_REF,
    AIS_NEG_AN1
  } ais_neg_t;

  typedef enum logic {
    AIS_SEQ_FIRST,
    AIS_SEQ_RUN
  } ais_seq_t;
endpackage : ais_pkg

// [core/ais_clk_if.sv]
`timescale 1ns/1ps
`default_nettype none
interface ais_clk_if;
  logic [7:0] divider;
  logic tick;
  modport ctrl (output divider, input tick);
  modport gen (input divider, output tick);
endinterface : ais_clk_if
`default_nettype wire

// [core/ais_clk_div.sv]
`timescale 1ns/1ps
`default_nettype none
`include "ais_cfg.svh"
module ais_clk_div
  import ais_pkg::*;
(
  input wire logic core_clk,
  input wire logic sys_rst,
  ais_clk_if.gen link
);
  logic [7:0] cnt_reg;
  logic [7:0] cnt_next;
  logic tick_reg;
  wire logic wrap = (cnt_reg >= link.divider);

  // One tick every (divider + 1) core cycles; core clock is the instruction cycle
  assign cnt_next = wrap ? `AIS_RESET_DIV : 8'(cnt_reg + 8'h01);
  assign link.tick = tick_reg;

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      cnt_reg <= `AIS_RESET_DIV;
      tick_reg <= 1'b0;
    end else begin
      cnt_reg <= cnt_next;
      tick_reg <= wrap;
    end
  end

  // No tick follows a tick in the next cycle while the divider seen in the tick cycle is nonzero
  a_tick_spacing: assert property (@(posedge core_clk) disable iff (sys_rst)
    tick_reg && (link.divider != 8'h00) |=> !tick_reg)
    else $error("conversion clock ticks too close");
endmodule : ais_clk_div
`default_nettype wire

// [core/ais_scan_pick.sv]
`timescale 1ns/1ps
`default_nettype none
`include "ais_cfg.svh"
module ais_scan_pick
  import ais_pkg::*;
(
  input wire logic [17:0] enabled,
  input wire logic [4:0] current,
  output logic [4:0] next_code,
  output logic any
);
  // Scan order: AN0..AN15, half band gap, full band gap, then wrap
  logic [4:0] first_code;
  logic [4:0] after_code;
  logic found_after;

  always_comb begin
    first_code = 5'h00;
    after_code = 5'h00;
    found_after = 1'b0;
    for (int i = 17; i >= 0; i--) begin
      if (enabled[i]) begin
        first_code = 5'(i);
        if (5'(i) > current) begin
          after_code = 5'(i);
          found_after = 1'b1;
        end
      end
    end
  end

  assign next_code = found_after ? after_code : first_code;
  assign any = |enabled;
endmodule : ais_scan_pick
`default_nettype wire

// [core/ais_top.sv]
// Local design decisions: the plain strobed port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
`include "ais_cfg.svh"
// Notes on behaviour
// - B negative bit picks input 1 or negative reference
// - B positive code: AN0-15, half/full band gap
// - A negative bit picks input 1 or negative reference
// - A positive code decodes like B
// - Pin config bit one means digital mode
// - Band-gap scan bit one excludes band gap
// - Half band-gap scan bit one excludes it
// - Scan mask bit one includes that channel
// - Conversion clock is cycle times divider plus one
// - Unimplemented bits read zero, writes ignored
// - Alternate mode: A first, then B/A alternate
// - Scan enable scans A positive input
module ais_top
  import ais_pkg::*;
(
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic [2:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic sample_strobe,
  output logic [15:0] reg_rdata,
  output logic [15:0] pin_digital_mode,
  output logic [15:0] analog_sample_en,
  output logic [4:0] pos_code,
  output logic pos_analog_valid,
  output logic pos_half_bg,
  output logic pos_full_bg,
  output logic neg_analog_input_1,
  output logic mux_b_active,
  output logic conv_clock_tick
);
  // ----------------------------------------
  // Register file
  // ----------------------------------------
  logic [15:0] mux_sel_reg;
  logic [15:0] pin_cfg_lo_reg;
  logic [15:0] pin_cfg_hi_reg;
  logic [15:0] scan_mask_reg;
  logic [15:0] control_reg;
  logic [15:0] rdata_reg;
  logic [15:0] rdata_next;

  wire logic wr_mux = reg_wr && (reg_addr == `AIS_IDX_MUX_SEL);
  wire logic wr_plo = reg_wr && (reg_addr == `AIS_IDX_PIN_LO);
  wire logic wr_phi = reg_wr && (reg_addr == `AIS_IDX_PIN_HI);
  wire logic wr_scan = reg_wr && (reg_addr == `AIS_IDX_SCAN_MASK);
  wire logic wr_ctl = reg_wr && (reg_addr == `AIS_IDX_CONTROL);

  // Control fields
  wire logic alternate_sample_enable = control_reg[`AIS_CTL_ALT_BIT];
  wire logic scan_enable_a = control_reg[`AIS_CTL_SCAN_BIT];
  wire logic [7:0] conv_clock_divider = control_reg[`AIS_CTL_DIV_HI:`AIS_CTL_DIV_LO];

  wire logic neg_select_b = mux_sel_reg[`AIS_NEG_B_BIT];
  wire logic [4:0] pos_select_b = mux_sel_reg[`AIS_POS_B_HI:`AIS_POS_B_LO];
  wire logic neg_select_a = mux_sel_reg[`AIS_NEG_A_BIT];
  wire logic [4:0] pos_select_a = mux_sel_reg[`AIS_POS_A_HI:`AIS_POS_A_LO];
  wire logic bandgap_scan_disable = pin_cfg_hi_reg[`AIS_BG_BIT];
  wire logic half_bandgap_scan_disable = pin_cfg_hi_reg[`AIS_HBG_BIT];

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      mux_sel_reg <= `AIS_RESET_WORD;
      pin_cfg_lo_reg <= `AIS_RESET_WORD;
      pin_cfg_hi_reg <= `AIS_RESET_WORD;
      scan_mask_reg <= `AIS_RESET_WORD;
      control_reg <= `AIS_RESET_WORD;
    end else begin
      // Masks keep unimplemented positions at zero
      if (wr_mux) mux_sel_reg <= reg_wdata & `AIS_MUX_SEL_MASK;
      if (wr_plo) pin_cfg_lo_reg <= reg_wdata;
      if (wr_phi) pin_cfg_hi_reg <= reg_wdata & `AIS_PIN_HI_MASK;
      if (wr_scan) scan_mask_reg <= reg_wdata;
      if (wr_ctl) control_reg <= reg_wdata & `AIS_CTL_MASK;
    end
  end

  // ----------------------------------------
  // Decode of positive and negative selects
  // ----------------------------------------
  function automatic ais_src_t decode_pos(input logic [4:0] code);
    if (code <= `AIS_CODE_LAST_AN) decode_pos = AIS_SRC_ANALOG;
    else if (code == `AIS_CODE_HALF_BG) decode_pos = AIS_SRC_HALF_BG;
    else if (code == `AIS_CODE_FULL_BG) decode_pos = AIS_SRC_FULL_BG;
    else decode_pos = AIS_SRC_NONE; // Unused codes pick nothing
  endfunction : decode_pos

  function automatic ais_neg_t decode_neg(input logic bit_in);
    decode_neg = bit_in ? AIS_NEG_AN1 : AIS_NEG_REF;
  endfunction : decode_neg

  // ----------------------------------------
  // Sample sequencing and scan
  // ----------------------------------------
  ais_seq_t seq_reg;
  ais_seq_t seq_next;
  logic use_b_reg;
  logic use_b_next;
  logic [4:0] scan_code_reg;
  logic [4:0] scan_code_next;
  logic [4:0] scan_pick;
  logic scan_any;
  logic [17:0] scan_set;

  // Scan set: 16 pins, then half band gap, then full band gap
  assign scan_set = {~bandgap_scan_disable, ~half_bandgap_scan_disable,
                     scan_mask_reg};

  ais_scan_pick u_pick (
    .enabled(scan_set),
    .current(scan_code_reg),
    .next_code(scan_pick),
    .any(scan_any)
  );

  // Alternation only starts after the first sample uses A
  always_comb begin
    seq_next = seq_reg;
    use_b_next = use_b_reg;
    case (seq_reg)
      AIS_SEQ_FIRST: begin
        use_b_next = 1'b0;
        if (sample_strobe && alternate_sample_enable) seq_next = AIS_SEQ_RUN;
      end
      AIS_SEQ_RUN: begin
        if (!alternate_sample_enable) begin
          seq_next = AIS_SEQ_FIRST;
          use_b_next = 1'b0;
        end else if (sample_strobe) begin
          use_b_next = ~use_b_reg;
        end
      end
      default: begin
        seq_next = AIS_SEQ_FIRST;
        use_b_next = 1'b0;
      end
    endcase
  end

  // Scan advances on samples taken through setting A
  assign scan_code_next = !scan_enable_a ? `AIS_SCAN_NONE :
                          (sample_strobe && !use_b_reg) ? scan_pick : scan_code_reg;

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      seq_reg <= AIS_SEQ_FIRST;
      use_b_reg <= 1'b0;
      scan_code_reg <= `AIS_SCAN_NONE;
    end else begin
      seq_reg <= seq_next;
      use_b_reg <= use_b_next;
      scan_code_reg <= scan_code_next;
    end
  end

  // Code reported before any scan sample is the first enabled channel
  wire logic [4:0] scan_now = (scan_code_reg == `AIS_SCAN_NONE) ? scan_pick : scan_code_reg;
  wire logic [4:0] code_a = (scan_enable_a && scan_any) ? scan_now : pos_select_a;
  wire logic [4:0] code_sel = use_b_reg ? pos_select_b : code_a;
  wire ais_src_t src_sel = decode_pos(code_sel);
  wire ais_neg_t neg_sel = decode_neg(use_b_reg ? neg_select_b : neg_select_a);

  // ----------------------------------------
  // Conversion clock
  // ----------------------------------------
  ais_clk_if clk_link ();
  assign clk_link.divider = conv_clock_divider;

  ais_clk_div u_div (
    .core_clk(core_clk),
    .sys_rst(sys_rst),
    .link(clk_link)
  );

  // ----------------------------------------
  // Read path and registered outputs
  // ----------------------------------------
  wire logic [15:0] status_word = {14'h0000, seq_reg == AIS_SEQ_RUN, use_b_reg};
  wire logic [15:0] sample_word = {11'h000, scan_code_reg};

  always_comb begin
    rdata_next = `AIS_RESET_WORD;
    if (reg_rd) begin
      case (reg_addr)
        `AIS_IDX_MUX_SEL: rdata_next = mux_sel_reg;
        `AIS_IDX_PIN_LO: rdata_next = pin_cfg_lo_reg;
        `AIS_IDX_PIN_HI: rdata_next = pin_cfg_hi_reg;
        `AIS_IDX_SCAN_MASK: rdata_next = scan_mask_reg;
        `AIS_IDX_CONTROL: rdata_next = control_reg;
        `AIS_IDX_STATUS: rdata_next = status_word;
        `AIS_IDX_SAMPLE: rdata_next = sample_word;
        default: rdata_next = `AIS_RESET_WORD;
      endcase
    end
  end

  logic [15:0] pdm_reg;
  logic [15:0] asen_reg;
  logic [4:0] pos_reg;
  logic pav_reg;
  logic phb_reg;
  logic pfb_reg;
  logic neg_reg;
  logic mb_reg;
  logic tick_reg;

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      rdata_reg <= `AIS_RESET_WORD;
      pdm_reg <= `AIS_RESET_WORD;
      asen_reg <= ~`AIS_RESET_WORD;
      pos_reg <= 5'h00;
      pav_reg <= 1'b0;
      phb_reg <= 1'b0;
      pfb_reg <= 1'b0;
      neg_reg <= 1'b0;
      mb_reg <= 1'b0;
      tick_reg <= 1'b0;
    end else begin
      rdata_reg <= rdata_next;
      pdm_reg <= pin_cfg_lo_reg;
      asen_reg <= ~pin_cfg_lo_reg;
      pos_reg <= code_sel;
      pav_reg <= (src_sel == AIS_SRC_ANALOG);
      phb_reg <= (src_sel == AIS_SRC_HALF_BG);
      pfb_reg <= (src_sel == AIS_SRC_FULL_BG);
      neg_reg <= (neg_sel == AIS_NEG_AN1);
      mb_reg <= use_b_reg;
      tick_reg <= clk_link.tick;
    end
  end

  assign reg_rdata = rdata_reg;
  assign pin_digital_mode = pdm_reg;
  assign analog_sample_en = asen_reg;
  assign pos_code = pos_reg;
  assign pos_analog_valid = pav_reg;
  assign pos_half_bg = phb_reg;
  assign pos_full_bg = pfb_reg;
  assign neg_analog_input_1 = neg_reg;
  assign mux_b_active = mb_reg;
  assign conv_clock_tick = tick_reg;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  sequence s_alt_sample;
    alternate_sample_enable && sample_strobe && seq_reg == AIS_SEQ_RUN;
  endsequence

  // A sample through setting A while scanning moves the scan pointer
  sequence s_scan_sample;
    scan_enable_a && sample_strobe && !use_b_reg;
  endsequence

  sequence s_scan_idle;
    !scan_enable_a;
  endsequence

  a_alt_toggle: assert property (@(posedge core_clk) disable iff (sys_rst)
    s_alt_sample ##0 (wr_ctl == 1'b0) |=> use_b_reg != $past(use_b_reg))
    else $error("alternate sampling did not swap settings");
  a_alt_first: assert property (@(posedge core_clk) disable iff (sys_rst)
    seq_reg == AIS_SEQ_FIRST |=> !use_b_reg)
    else $error("first sample did not use setting A");
  a_a_only: assert property (@(posedge core_clk) disable iff (sys_rst)
    !alternate_sample_enable |=> !use_b_reg)
    else $error("setting B used without alternation");

  // ----------------------------------------
  // Register and read path checks
  // ----------------------------------------
  a_unimpl_zero: assert property (@(posedge core_clk) disable iff (sys_rst)
    ((mux_sel_reg & ~`AIS_MUX_SEL_MASK) == 16'h0000) &&
    ((pin_cfg_hi_reg & ~`AIS_PIN_HI_MASK) == 16'h0000))
    else $error("unimplemented bit set");
  a_read_lat: assert property (@(posedge core_clk) disable iff (sys_rst)
    reg_rd && reg_addr == `AIS_IDX_PIN_LO && !wr_plo |=> reg_rdata == $past(pin_cfg_lo_reg))
    else $error("read data wrong");
  a_read_scan: assert property (@(posedge core_clk) disable iff (sys_rst)
    reg_rd && reg_addr == `AIS_IDX_SAMPLE |=> reg_rdata == {11'h000, $past(scan_code_reg)})
    else $error("scan code read wrong");
  // Idle read data is zero so a stale word is never taken for an answer
  a_rdata_idle: assert property (@(posedge core_clk) disable iff (sys_rst)
    !reg_rd |=> reg_rdata == `AIS_RESET_WORD)
    else $error("read data left standing");

  // ----------------------------------------
  // Routing and decode checks
  // ----------------------------------------
  a_neg_out: assert property (@(posedge core_clk) disable iff (sys_rst)
    !use_b_reg |=> neg_analog_input_1 == $past(neg_select_a))
    else $error("negative select A not routed");
  a_neg_b_out: assert property (@(posedge core_clk) disable iff (sys_rst)
    use_b_reg |=> neg_analog_input_1 == $past(neg_select_b))
    else $error("negative select B not routed");
  a_pos_decode: assert property (@(posedge core_clk) disable iff (sys_rst)
    code_sel == `AIS_CODE_FULL_BG |=> pos_full_bg && !pos_analog_valid)
    else $error("band gap code misdecoded");
  a_half_decode: assert property (@(posedge core_clk) disable iff (sys_rst)
    code_sel == `AIS_CODE_HALF_BG |=> pos_half_bg && !pos_full_bg && !pos_analog_valid)
    else $error("half band gap code misdecoded");
  a_analog_decode: assert property (@(posedge core_clk) disable iff (sys_rst)
    code_sel <= `AIS_CODE_LAST_AN |=> pos_analog_valid && !pos_half_bg && !pos_full_bg)
    else $error("analog input code misdecoded");
  a_pos_b_out: assert property (@(posedge core_clk) disable iff (sys_rst)
    use_b_reg |=> pos_code == $past(pos_select_b) && mux_b_active)
    else $error("positive select B not routed");
  a_pin_mode: assert property (@(posedge core_clk) disable iff (sys_rst)
    1'b1 |=> pin_digital_mode == $past(pin_cfg_lo_reg))
    else $error("pin mode mismatch");
  a_analog_en: assert property (@(posedge core_clk) disable iff (sys_rst)
    1'b1 |=> analog_sample_en == ~$past(pin_cfg_lo_reg))
    else $error("analog sample enable mismatch");

  // ----------------------------------------
  // Scan checks
  // ----------------------------------------
  a_scan_excl: assert property (@(posedge core_clk) disable iff (sys_rst)
    s_scan_sample ##0 bandgap_scan_disable |=> scan_code_reg != `AIS_CODE_FULL_BG)
    else $error("excluded band gap scanned");
  a_hbg_excl: assert property (@(posedge core_clk) disable iff (sys_rst)
    s_scan_sample ##0 half_bandgap_scan_disable |=> scan_code_reg != `AIS_CODE_HALF_BG)
    else $error("excluded half band gap scanned");
  a_scan_member: assert property (@(posedge core_clk) disable iff (sys_rst)
    s_scan_sample ##0 scan_any |-> scan_set[scan_pick])
    else $error("scan picked a channel outside the set");
  a_scan_hold: assert property (@(posedge core_clk) disable iff (sys_rst)
    scan_enable_a && !sample_strobe |=> scan_code_reg == $past(scan_code_reg))
    else $error("scan moved without a sample");
  a_scan_stop: assert property (@(posedge core_clk) disable iff (sys_rst)
    s_scan_idle |=> scan_code_reg == `AIS_SCAN_NONE)
    else $error("scan pointer kept while scan off");
  a_scan_plain: assert property (@(posedge core_clk) disable iff (sys_rst)
    s_scan_idle ##0 !use_b_reg |=> pos_code == $past(pos_select_a))
    else $error("setting A code not used while scan off");
endmodule : ais_top
`default_nettype wire

// [verif/tb_ais_top.sv]
`timescale 1ns/1ps
`default_nettype none
`include "ais_cfg.svh"
module tb_ais_top
  import ais_pkg::*;
;
  logic core_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic [2:0] reg_addr = 3'h0;
  logic [15:0] reg_wdata = 16'h0000;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic sample_strobe = 1'b0;
  logic [15:0] reg_rdata, pin_digital_mode, analog_sample_en;
  logic [4:0] pos_code;
  logic pos_analog_valid, pos_half_bg, pos_full_bg;
  logic neg_analog_input_1, mux_b_active, conv_clock_tick;
  int error_cnt = 0;
  int n_compared = 0;
  logic [15:0] lfsr_reg = 16'h004D;
  logic [15:0] rv, got;
  logic [15:0] masks [5] = '{`AIS_MUX_SEL_MASK, 16'hFFFF, `AIS_PIN_HI_MASK, 16'hFFFF,
                            `AIS_CTL_MASK};

  ais_top dut_u (.core_clk(core_clk), .sys_rst(sys_rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .sample_strobe(sample_strobe),
    .reg_rdata(reg_rdata), .pin_digital_mode(pin_digital_mode),
    .analog_sample_en(analog_sample_en), .pos_code(pos_code),
    .pos_analog_valid(pos_analog_valid), .pos_half_bg(pos_half_bg),
    .pos_full_bg(pos_full_bg), .neg_analog_input_1(neg_analog_input_1),
    .mux_b_active(mux_b_active), .conv_clock_tick(conv_clock_tick));

  initial begin
    forever #10 core_clk = ~core_clk;
  end

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic [15:0] lfsr_step(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : lfsr_step

  // Expected {analog, half band gap, full band gap} for a positive code
  function automatic logic [2:0] exp_dec(input logic [4:0] c);
    if (c <= `AIS_CODE_LAST_AN) return 3'h4;
    if (c == `AIS_CODE_HALF_BG) return 3'h2;
    if (c == `AIS_CODE_FULL_BG) return 3'h1;
    return 3'h0;
  endfunction : exp_dec

  task automatic rnd();
    lfsr_reg = lfsr_step(lfsr_reg);
    rv = lfsr_reg;
  endtask : rnd

  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      error_cnt++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  task automatic wr(input logic [2:0] a, input logic [15:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask : wr

  task automatic rd(input logic [2:0] a, output logic [15:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1;
    d = reg_rdata;
  endtask : rd

  task automatic strobe();
    @(posedge core_clk);
    sample_strobe <= 1'b1;
    @(posedge core_clk);
    sample_strobe <= 1'b0;
    repeat (2) @(posedge core_clk);
    #1;
  endtask : strobe

  task automatic do_reset();
    @(posedge core_clk);
    sys_rst <= 1'b1;
    repeat (12) @(posedge core_clk);
    sys_rst <= 1'b0;
    for (int i = 0; i < 6; i++) begin
      rd(3'(i), got);
      chk("reset_word", got, 16'h0000);
    end
    chk("reset_dig", pin_digital_mode, 16'h0000);
    chk("reset_ana", analog_sample_en, 16'hFFFF);
    chk("reset_code", {pos_code, pos_analog_valid}, 6'h01);
  endtask : do_reset

  // Gap in core cycles up to the next conversion clock tick
  task automatic tick_gap(output int gap);
    gap = 0;
    do begin
      @(posedge core_clk);
      #1;
      gap++;
    end while (conv_clock_tick !== 1'b1 && gap < 600);
  endtask : tick_gap

  task automatic tally_and_finish();
    $display("compared %0d mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : tally_and_finish

  initial begin
    repeat (50000) @(posedge core_clk);
    error_cnt++;
    tally_and_finish();
  end

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  initial begin
    int lst[$];
    int idx, g, n;
    logic [4:0] ac, bc, e;
    logic use_b;
    logic [1:0] hi;
    logic [7:0] dv;
    do_reset();
    for (int k = 0; k < 8; k++) begin
      for (int a = 0; a < 5; a++) begin
        rnd();
        if (k == 0) rv = 16'hFFFF;
        if (k == 1) rv = 16'h0000;
        // Keep both positive selects inside the implemented codes
        if (a == 0) rv = rv & 16'hEFEF;
        wr(3'(a), rv);
        rd(3'(a), got);
        chk("readback", got, rv & masks[a]);
        if (a == 1) chk("pin_mode", {pin_digital_mode, analog_sample_en}, {rv, ~rv});
      end
    end
    wr(3'h7, 16'hFFFF);
    rd(3'h7, got);
    chk("unmapped", got, 16'h0000);
    // Every implemented code on setting A when plain; odd codes only on each setting when alternating
    for (int alt = 0; alt < 2; alt++) begin
      do_reset();
      wr(`AIS_IDX_CONTROL, 16'(alt));
      for (int k = 0; k < 36; k++) begin
        bc = 5'(k % 18);
        ac = 5'(17 - k % 18);
        wr(`AIS_IDX_MUX_SEL, {1'b1, 2'b00, bc, 1'b0, 2'b00, ac});
        strobe();
        use_b = (alt == 1) && (k % 2 == 1);
        e = use_b ? bc : ac;
        chk("mux_b", mux_b_active, use_b);
        chk("neg_sel", neg_analog_input_1, use_b);
        chk("pos_code", pos_code, e);
        chk("decode", {pos_analog_valid, pos_half_bg, pos_full_bg}, exp_dec(e));
        rd(`AIS_IDX_STATUS, got);
        chk("status_b", got[0], use_b);
        chk("status_run", got[1], alt == 1);
      end
    end
    wr(`AIS_IDX_CONTROL, 16'h0000);
    for (int cfg = 0; cfg < 3; cfg++) begin
      rnd();
      rv = (cfg == 0) ? 16'h8001 : rv;
      hi = 2'(cfg);
      lst.delete();
      for (int i = 0; i < 16; i++) if (rv[i]) lst.push_back(i);
      if (!hi[0]) lst.push_back(16);
      if (!hi[1]) lst.push_back(17);
      n = lst.size();
      wr(`AIS_IDX_SCAN_MASK, rv);
      wr(`AIS_IDX_PIN_HI, {14'h0000, hi});
      wr(`AIS_IDX_CONTROL, 16'h0400);
      strobe();
      idx = -1;
      for (int j = 0; j < n; j++) if (lst[j] == pos_code) idx = j;
      chk("scan_first", idx >= 0, 1'b1);
      for (int s = 0; s < 2 * n + 2; s++) begin
        strobe();
        idx = (idx + 1) % n;
        e = 5'(lst[idx]);
        chk("scan_code", pos_code, e);
        chk("scan_dec", {pos_analog_valid, pos_half_bg, pos_full_bg}, exp_dec(e));
        rd(`AIS_IDX_SAMPLE, got);
        chk("scan_reg", got, 16'(e));
      end
      wr(`AIS_IDX_CONTROL, 16'h0000);
    end
    for (int t = 0; t < 5; t++) begin
      rnd();
      dv = (t == 0) ? 8'h00 : (t == 1) ? 8'h01 : (t == 2) ? 8'hFF : rv[5:0];
      wr(`AIS_IDX_CONTROL, {8'h00, dv});
      tick_gap(g);
      tick_gap(g);
      tick_gap(g);
      chk("tick_gap", 32'(g), 32'(dv) + 32'h1);
    end
    tally_and_finish();
  end
endmodule : tb_ais_top
`default_nettype wire
